// File: logic/scd_map.vh
// register offsets, field positions, reset values and divide ratios of the clock block
`ifndef SCD_MAP_VH
`define SCD_MAP_VH

// register byte addresses
`define SCD_ADDR_MODE         4'h0
`define SCD_ADDR_MODE2        4'h4
`define SCD_ADDR_STATUS       4'h8

// cpu_mode_register fields
`define SCD_MODE_DIV_HI       7
`define SCD_MODE_DIV_LO       6
`define SCD_MODE_MAIN_STOP    5
`define SCD_MODE_SUB_ON       4
`define SCD_MODE_LOW_SPEED    3

// cpu_mode_register_second fields
`define SCD_MODE2_INT_STOP    0

// divide field codes
`define SCD_DIV_MAIN2         2'h0
`define SCD_DIV_MAIN8         2'h1
`define SCD_DIV_MAIN4         2'h2
`define SCD_DIV_INTERNAL      2'h3

// reset values
`define SCD_MODE_RST_INT      8'hE0
`define SCD_MODE_RST_MAIN8    8'h40
`define SCD_MODE2_RST_INT     8'h00
`define SCD_MODE2_RST_MAIN8   8'h01

// source select codes
`define SCD_SRC_INTERNAL      2'h0
`define SCD_SRC_MAIN          2'h1
`define SCD_SRC_SUB           2'h2

// half periods, in oscillator rising edges
`define SCD_HALF_INTERNAL     5'h10
`define SCD_HALF_MAIN8        5'h04
`define SCD_HALF_MAIN4        5'h02
`define SCD_HALF_MAIN2        5'h01
`define SCD_HALF_SUB          5'h01

// bus responses
`define SCD_RESP_OKAY         2'h0
`define SCD_RESP_SLVERR       2'h2

`endif

// File: logic/scd_divider.v
// edge-counting divider for one sampled oscillator input
`timescale 1ns/1ps
module scd_divider
#(
   parameter W = 5
)
(
   // clock and control
   input  wire         clk,
   input  wire         sys_rst,
   input  wire         ce,
   // oscillator and ratio
   input  wire         osc_in,
   input  wire         osc_run,
   input  wire [W-1:0] half,
   // divided output
   output reg          div_out
);

   localparam [W-1:0] CNT_ONE = {{(W-1){1'b0}}, 1'b1};

   reg         osc_prev;
   reg [W-1:0] cnt;
   wire        rise = osc_in & ~osc_prev;

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         osc_prev <= 1'b0;
         cnt      <= {W{1'b0}};
         div_out  <= 1'b0;
      end
      else if (ce)
      begin
         osc_prev <= osc_in;
         // a stopped oscillator gives no edges, output holds
         if (osc_run && rise)
         begin
            if (cnt + CNT_ONE >= half)
            begin
               cnt     <= {W{1'b0}};
               div_out <= ~div_out;
            end
            else
               cnt <= cnt + CNT_ONE;
         end
      end
   end

endmodule

// File: logic/scd_clock_mux.v
// glitch-free selector of the divided clock sources
`timescale 1ns/1ps
`include "scd_map.vh"
module scd_clock_mux
(
   // clock and control
   input  wire       clk,
   input  wire       sys_rst,
   input  wire       ce,
   // divided sources
   input  wire       clk_internal,
   input  wire       clk_main,
   input  wire       clk_sub,
   input  wire [1:0] sel_req,
   // system clock
   output reg  [1:0] sel_cur,
   output reg        sys_clk
);

   function src_level;
      input [1:0] sel;
      input       a;
      input       b;
      input       c;
      begin
         case (sel)
            `SCD_SRC_MAIN: src_level = b;
            `SCD_SRC_SUB:  src_level = c;
            default:       src_level = a;
         endcase
      end
   endfunction

   wire next_level = src_level(sel_cur, clk_internal, clk_main, clk_sub);
   wire req_level  = src_level(sel_req, clk_internal, clk_main, clk_sub);

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         sel_cur <= `SCD_SRC_INTERNAL;
         sys_clk <= 1'b0;
      end
      else if (ce)
      begin
         // switch only while old and new are both low, no runt pulse
         if (sel_req != sel_cur && !next_level && !req_level && !sys_clk)
         begin
            sel_cur <= sel_req;
            sys_clk <= 1'b0;
         end
         else
            sys_clk <= next_level;
      end
   end

endmodule

// File: logic/scd_clock_source.v
// system clock source selection and division with register access
//
// Notes on behaviour
// R1 - strap low or flash: internal oscillator only
// R2 - strap high: main oscillator, divide by eight
// R3 - main mode ignores main stop bit
// R4 - low-speed: port switch zero halts sub-clock
// R5 - internal mode: internal stop works only on ROM variant
// R6 - internal mode divides internal oscillator by 32
// R7 - main mode divides by eight, four, two
// R8 - one glitch-free multiplexer picks system clock
// R9 - low-speed clock is half sub-clock
// R10 - mode bits five, four and second bit zero
// R11 - low-speed: ROM stops internal, flash obeys bit
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "scd_map.vh"
module scd_clock_source
#(
   parameter FLASH_VARIANT = 0
)
(
   // clock and control
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        ce,
   // oscillator and strap pins
   input  wire        reset_source_strap,
   input  wire        main_osc_input,
   input  wire        sub_osc_input,
   input  wire        int_osc_input,
   // oscillator controls
   output reg         main_osc_run,
   output reg         sub_osc_run,
   output reg         int_osc_run,
   output reg         sub_pins_gpio,
   // system clock
   output wire        sys_clk,
   // axi4-lite write address
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   reg  [7:0] cpu_mode_register;
   reg  [7:0] cpu_mode_register_second;
   reg        init_pending;
   reg  [3:0] aw_addr;
   reg        aw_held;
   reg  [7:0] w_data;
   reg        w_lane0;
   reg        w_held;
   wire [1:0] sel_cur;
   wire       div_int;
   wire       div_main;
   wire       div_sub;

   // ------------------------------------------------
   // mode decoding
   // ------------------------------------------------
   function [1:0] source_of;
      input [7:0] mode;
      begin
         if (mode[`SCD_MODE_LOW_SPEED])
            source_of = `SCD_SRC_SUB;
         else if (mode[`SCD_MODE_DIV_HI:`SCD_MODE_DIV_LO] == `SCD_DIV_INTERNAL)
            source_of = `SCD_SRC_INTERNAL;
         else
            source_of = `SCD_SRC_MAIN;
      end
   endfunction

   function [4:0] main_half;
      input [1:0] div;
      begin
         case (div)
            `SCD_DIV_MAIN8: main_half = `SCD_HALF_MAIN8;
            `SCD_DIV_MAIN4: main_half = `SCD_HALF_MAIN4;
            default:        main_half = `SCD_HALF_MAIN2;
         endcase
      end
   endfunction

   wire [1:0] mode_src  = source_of(cpu_mode_register);
   wire       main_stop = cpu_mode_register[`SCD_MODE_MAIN_STOP];
   wire       sub_on    = cpu_mode_register[`SCD_MODE_SUB_ON];
   wire       int_stop  = cpu_mode_register_second[`SCD_MODE2_INT_STOP];

   // ------------------------------------------------
   // oscillator run controls
   // ------------------------------------------------
   reg next_main_run;
   reg next_int_run;

   always @*
   begin
      // R10 main gated by bit five
      next_main_run = ~main_stop;
      // R3 main mode keeps main running
      if (mode_src == `SCD_SRC_MAIN)
         next_main_run = 1'b1;
      // R10 internal gated by second bit zero
      next_int_run = ~int_stop;
      // R5 flash ignores internal stop in internal mode
      if (mode_src == `SCD_SRC_INTERNAL && FLASH_VARIANT != 0)
         next_int_run = 1'b1;
      // R11 low-speed stops internal on ROM
      if (mode_src == `SCD_SRC_SUB && FLASH_VARIANT == 0)
         next_int_run = 1'b0;
   end

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         main_osc_run  <= 1'b0;
         sub_osc_run   <= 1'b0;
         int_osc_run   <= 1'b1;
         sub_pins_gpio <= 1'b1;
      end
      else if (ce)
      begin
         main_osc_run  <= next_main_run;
         // R4 port switch zero halts sub-clock
         sub_osc_run   <= sub_on;
         sub_pins_gpio <= ~sub_on;
         int_osc_run   <= next_int_run;
      end
   end

   // ------------------------------------------------
   // dividers and source multiplexer
   // ------------------------------------------------
   // R6 internal divided by 32
   scd_divider #(.W(5)) u_div_int
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .osc_in  (int_osc_input),
      .osc_run (int_osc_run),
      .half    (`SCD_HALF_INTERNAL),
      .div_out (div_int)
   );

   // R7 main divided by eight, four, two
   scd_divider #(.W(5)) u_div_main
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .osc_in  (main_osc_input),
      .osc_run (main_osc_run),
      .half    (main_half(cpu_mode_register[`SCD_MODE_DIV_HI:`SCD_MODE_DIV_LO])),
      .div_out (div_main)
   );

   // R9 sub-clock halved
   scd_divider #(.W(5)) u_div_sub
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .osc_in  (sub_osc_input),
      .osc_run (sub_osc_run),
      .half    (`SCD_HALF_SUB),
      .div_out (div_sub)
   );

   // R8 single glitch-free selector
   scd_clock_mux u_mux
   (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .ce           (ce),
      .clk_internal (div_int),
      .clk_main     (div_main),
      .clk_sub      (div_sub),
      .sel_req      (mode_src),
      .sel_cur      (sel_cur),
      .sys_clk      (sys_clk)
   );

   // ------------------------------------------------
   // mode registers and write channel
   // ------------------------------------------------
   wire do_write = aw_held && w_held && !s_axi_bvalid;

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         // R1 reset into internal mode
         cpu_mode_register        <= `SCD_MODE_RST_INT;
         cpu_mode_register_second <= `SCD_MODE2_RST_INT;
         init_pending             <= 1'b1;
         aw_held                  <= 1'b0;
         w_held                   <= 1'b0;
         aw_addr                  <= 4'h0;
         w_data                   <= 8'h00;
         w_lane0                  <= 1'b0;
         s_axi_awready            <= 1'b0;
         s_axi_wready             <= 1'b0;
         s_axi_bvalid             <= 1'b0;
         s_axi_bresp              <= `SCD_RESP_OKAY;
      end
      else if (ce)
      begin
         s_axi_awready <= !aw_held && !s_axi_awready;
         s_axi_wready  <= !w_held && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata[7:0];
            w_lane0      <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (init_pending)
         begin
            init_pending <= 1'b0;
            // R2 strap high starts main divided by eight
            if (FLASH_VARIANT == 0 && reset_source_strap)
            begin
               cpu_mode_register        <= `SCD_MODE_RST_MAIN8;
               cpu_mode_register_second <= `SCD_MODE2_RST_MAIN8;
            end
         end
         else if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `SCD_RESP_OKAY;
            case (aw_addr)
               `SCD_ADDR_MODE:
                  if (w_lane0)
                     cpu_mode_register <= w_data;
               `SCD_ADDR_MODE2:
                  if (w_lane0)
                     cpu_mode_register_second <= w_data;
               `SCD_ADDR_STATUS:
                  s_axi_bresp <= `SCD_RESP_OKAY;
               default:
                  s_axi_bresp <= `SCD_RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
         end
      end
   end

   // ------------------------------------------------
   // read channel
   // ------------------------------------------------
   reg [31:0] next_rdata;
   reg [1:0]  next_rresp;

   always @*
   begin
      next_rdata = 32'h00000000;
      next_rresp = `SCD_RESP_OKAY;
      case (s_axi_araddr)
         `SCD_ADDR_MODE:   next_rdata[7:0] = cpu_mode_register;
         `SCD_ADDR_MODE2:  next_rdata[7:0] = cpu_mode_register_second;
         `SCD_ADDR_STATUS: next_rdata[7:0] = {2'h0, sel_cur, sub_pins_gpio,
                                              int_osc_run, sub_osc_run, main_osc_run};
         default:          next_rresp = `SCD_RESP_SLVERR;
      endcase
   end

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `SCD_RESP_OKAY;
      end
      else if (ce)
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
                          (!s_axi_rvalid && !s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// File: testbench/scd_clock_source_props.sv
// assertion checker for the clock source block
`timescale 1ns/1ps
module scd_clock_source_props
#(
   parameter FLASH_VARIANT = 0
)
(
   input wire        clk,
   input wire        sys_rst,
   input wire        reset_source_strap,
   input wire        main_osc_run,
   input wire        sub_osc_run,
   input wire        int_osc_run,
   input wire        sub_pins_gpio,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // ------
   // oscillator states
   // ------
   sequence s_int_only;
      int_osc_run && !main_osc_run && !sub_osc_run && sub_pins_gpio;
   endsequence
   sequence s_main_only;
      main_osc_run && !int_osc_run && !sub_osc_run && sub_pins_gpio;
   endsequence

   chk_reset_state:
      assert property (disable iff (1'h0) sys_rst |=> s_int_only)
      else $error("bad oscillator state in reset");
   chk_strap_low:
      assert property ($fell(sys_rst) && (FLASH_VARIANT != 0 || !reset_source_strap)
         |-> s_int_only [*4]) else $error("internal start not kept");
   chk_strap_high:
      assert property ($fell(sys_rst) && reset_source_strap && FLASH_VARIANT == 0
         |-> ##3 s_main_only [*2]) else $error("main start not reached");

   // ------
   // register bus
   // ------
   chk_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_write_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   chk_bresp_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_ready_busy:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready while answer held");
endmodule

bind scd_clock_source scd_clock_source_props #(.FLASH_VARIANT(FLASH_VARIANT)) u_props
(
   .clk, .sys_rst, .reset_source_strap, .main_osc_run, .sub_osc_run, .int_osc_run,
   .sub_pins_gpio, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

// File: testbench/scd_clock_source_bench.sv
// self-checking bench for the clock source block
`timescale 1ns/1ps
`include "scd_map.vh"
`define CHK(nm, e, g) \
   begin \
      n_checks = n_checks + 1; \
      if ((g) !== (e)) \
      begin \
         num_errors = num_errors + 1; \
         $display("Error %s expected %h seen %h", nm, e, g); \
      end \
   end
module scd_clock_source_bench;
   localparam MP = 4;
   localparam SP = 8;
   reg         clk = 1'h0;
   reg         sys_rst = 1'h1;
   reg         reset_source_strap = 1'h0;
   reg  [7:0]  cyc = 8'h00;
   reg  [3:0]  s_axi_awaddr = 4'h0;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg         s_axi_awvalid = 1'h0;
   reg         s_axi_wvalid = 1'h0;
   reg         s_axi_bready = 1'h0;
   reg  [3:0]  s_axi_araddr = 4'h0;
   reg         s_axi_arvalid = 1'h0;
   reg         s_axi_rready = 1'h0;
   wire        main_osc_run, sub_osc_run, int_osc_run, sub_pins_gpio, sys_clk;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   integer     num_errors = 0;
   integer     n_checks = 0;

   // oscillators: main and internal period 4 cycles, sub 8
   scd_clock_source #(.FLASH_VARIANT(0)) u_scd_clock_source
   (
      .clk, .sys_rst, .ce(1'h1), .reset_source_strap,
      .main_osc_input(cyc[1]), .sub_osc_input(cyc[2]), .int_osc_input(cyc[1]),
      .main_osc_run, .sub_osc_run, .int_osc_run, .sub_pins_gpio, .sys_clk,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );

   initial
   begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 8'h01;

   // ------
   // shared tasks
   // ------
   task conclude;
      begin
         $display("checks %0d errors %0d", n_checks, num_errors);
         if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask

   task guard(input late);
      begin
         if (late)
         begin
            num_errors = num_errors + 1;
            conclude;
         end
      end
   endtask

   task do_reset(input s);
      begin
         sys_rst <= 1'h1;
         reset_source_strap <= s;
         repeat (12) @(posedge clk);
         sys_rst <= 1'h0;
         repeat (4) @(posedge clk);
      end
   endtask

   // ready raised only after valid, so the hold checks see a stall
   task automatic wr(input [3:0] a, input [7:0] d, input [1:0] er);
      integer n;
      begin
         n = 0;
         s_axi_awaddr <= a;
         s_axi_wdata <= {24'h000000, d};
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         while (!(s_axi_bvalid && s_axi_bready) && n < 50)
         begin
            @(posedge clk);
            n = n + 1;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            s_axi_bready <= s_axi_bvalid && !s_axi_bready;
         end
         guard(!(s_axi_bvalid && s_axi_bready));
         `CHK("bresp", er, s_axi_bresp)
         repeat (4) @(posedge clk);
      end
   endtask

   task automatic rd(input [3:0] a, input [7:0] ed, input [1:0] er);
      integer n;
      begin
         n = 0;
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         while (!(s_axi_rvalid && s_axi_rready) && n < 50)
         begin
            @(posedge clk);
            n = n + 1;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            s_axi_rready <= s_axi_rvalid && !s_axi_rready;
         end
         guard(!(s_axi_rvalid && s_axi_rready));
         `CHK("rresp", er, s_axi_rresp)
         if (er == `SCD_RESP_OKAY) `CHK("rdata", {24'h000000, ed}, s_axi_rdata)
         repeat (2) @(posedge clk);
      end
   endtask

   // first period after a switch may be short, so the second is timed
   task automatic period(input integer e, input string nm);
      integer n, n0, k;
      reg     prv;
      begin
         n = 0;
         n0 = 0;
         k = 0;
         prv = sys_clk;
         while (k < 3 && n < 1000)
         begin
            @(posedge clk);
            n = n + 1;
            if (sys_clk && !prv) k = k + 1;
            if (sys_clk && !prv && k == 2) n0 = n;
            prv = sys_clk;
         end
         guard(k < 3);
         `CHK(nm, e, n - n0)
      end
   endtask

   // ------
   // scenarios
   // ------
   task sc_internal;
      begin
         do_reset(1'h0);
         `CHK("main_run", 1'h0, main_osc_run)
         `CHK("gpio", 1'h1, sub_pins_gpio)
         rd(`SCD_ADDR_MODE, `SCD_MODE_RST_INT, `SCD_RESP_OKAY);
         rd(`SCD_ADDR_MODE2, `SCD_MODE2_RST_INT, `SCD_RESP_OKAY);
         rd(`SCD_ADDR_STATUS, 8'h0C, `SCD_RESP_OKAY);
         period(32 * MP, "internal");
         rd(4'hC, 8'h00, `SCD_RESP_SLVERR);
         wr(4'hC, 8'hFF, `SCD_RESP_SLVERR);
         wr(`SCD_ADDR_STATUS, 8'hFF, `SCD_RESP_OKAY);
         rd(`SCD_ADDR_MODE, `SCD_MODE_RST_INT, `SCD_RESP_OKAY);
         wr(`SCD_ADDR_MODE2, 8'h01, `SCD_RESP_OKAY);
         `CHK("int_run", 1'h0, int_osc_run)
      end
   endtask

   task sc_main;
      begin
         do_reset(1'h1);
         `CHK("main_run", 1'h1, main_osc_run)
         `CHK("int_run", 1'h0, int_osc_run)
         rd(`SCD_ADDR_MODE, `SCD_MODE_RST_MAIN8, `SCD_RESP_OKAY);
         rd(`SCD_ADDR_MODE2, `SCD_MODE2_RST_MAIN8, `SCD_RESP_OKAY);
         period(8 * MP, "main8");
         wr(`SCD_ADDR_MODE, 8'h80, `SCD_RESP_OKAY);
         period(4 * MP, "main4");
         wr(`SCD_ADDR_MODE, 8'h20, `SCD_RESP_OKAY);
         period(2 * MP, "main2");
         `CHK("main_run", 1'h1, main_osc_run)
      end
   endtask

   task sc_low_speed;
      begin
         wr(`SCD_ADDR_MODE2, 8'h00, `SCD_RESP_OKAY);
         wr(`SCD_ADDR_MODE, 8'h18, `SCD_RESP_OKAY);
         `CHK("sub_run", 1'h1, sub_osc_run)
         `CHK("gpio", 1'h0, sub_pins_gpio)
         `CHK("int_run", 1'h0, int_osc_run)
         period(2 * SP, "sub");
         rd(`SCD_ADDR_STATUS, 8'h23, `SCD_RESP_OKAY);
         wr(`SCD_ADDR_MODE, 8'h38, `SCD_RESP_OKAY);
         `CHK("main_run", 1'h0, main_osc_run)
         wr(`SCD_ADDR_MODE, 8'h08, `SCD_RESP_OKAY);
         `CHK("sub_run", 1'h0, sub_osc_run)
         `CHK("main_run", 1'h1, main_osc_run)
      end
   endtask

   initial
   begin
      sc_internal;
      sc_main;
      sc_low_speed;
      conclude;
   end
endmodule
